// [iwl_pkg.sv]
// constants for the interrupt, wake-up and low-voltage status block
package iwl_pkg;
    // ========================================
    // register byte offsets on the bus
    localparam logic [7:0] OFS_FLAGS = 8'h00;
    localparam logic [7:0] OFS_MASK  = 8'h04;
    localparam logic [7:0] OFS_WAKE  = 8'h08;
    localparam logic [7:0] OFS_LVC   = 8'h0C;
    localparam logic [7:0] OFS_CONV  = 8'h10;
    localparam logic [7:0] OFS_RES   = 8'h14;
    localparam logic [7:0] OFS_GIE   = 8'h18;
    // ========================================
    // flag bit positions
    localparam int BIT_CMP   = 7;
    localparam int BIT_PW3   = 6;
    localparam int BIT_PW1   = 4;
    localparam int BIT_CONV  = 3;
    localparam int BIT_EXT   = 2;
    localparam int BIT_PINCH = 1;
    localparam int BIT_TMR   = 0;
    // low-voltage control fields
    localparam int LVC_FLAG  = 6;
    localparam int LVC_STATE = 5;
    localparam int LVC_IE    = 4;
    localparam int LVC_WE    = 3;
    localparam int LVC_EN    = 2;
    // threshold per level code, millivolts
    localparam int LV_MV_CODE3 = 2300;
    localparam int LV_MV_CODE2 = 3300;
    localparam int LV_MV_CODE1 = 4000;
    localparam int LV_MV_CODE0 = 4500;
    // ========================================
    // values after reset
    localparam logic [7:0]  RST_FLAGS = 8'h00;
    localparam logic [7:0]  RST_MASK  = 8'h00;
    localparam logic [2:0]  RST_WAKE  = 3'h0;
    localparam logic [1:0]  RST_LVSEL = 2'h0;
    localparam logic [11:0] RST_RES   = 12'h000;
    localparam logic [31:0] RST_RDATA = 32'h0000_0000;
endpackage

// [iwl_top.sv]
// interrupt flags, wake-up control and low-voltage status behind AHB-Lite
//
// Summary of operation
// - a flag bit reads 1 while its source has a pending request and its mask bit is 1
// - software writes only clear flags, never set them
// - flag reads return stored flags ANDed with the mask register
// - comparator flag bit 7 sets on any comparator output change
// - pulse flags bits 6..4 set when their generator reaches duration
// - conversion flag bit 3 sets when a conversion finishes
// - external flag bit 2 sets on a falling edge of the pin
// - pin-change flag bit 1 sets on any port 6 input change
// - timer flag bit 0 sets on timer overflow
// - completion loads result, clears running, sets flag together
// - wake register reads zero in bit 0 and bits 7..4
// - low-voltage flag bit 6 clears by software or hardware
// - state bit 5 reads 0 when supply at or below level
// - low-voltage interrupt requested only while enable bit 4 is 1
// - global enable set and cleared by instructions, gates all sources
// - low-voltage wake only while wake enable bit 3 is 1
// - detector enable bit 2; when off state reads 1
// - level codes 11,10,01,00 choose 2.3V,3.3V,4.0V,4.5V
// - writing 1 starts conversion; only completion clears running
//
// The AHB-Lite register port and the register offsets were decided locally.
`timescale 1ns/100ps
module iwl_top (
    input  wire logic        clock,
    input  wire logic        rst_n,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // event sources, same clock
    input  wire logic [2:0]  pulseDone,
    input  wire logic        convDone,
    input  wire logic [11:0] convResult,
    input  wire logic        timerOverflow,
    // asynchronous pins and analog levels
    input  wire logic        cmpOut,
    input  wire logic        extIrq_n,
    input  wire logic [7:0]  port6In,
    input  wire logic [3:0]  supplyBelow,
    // core side
    input  wire logic        globalIrqEnableInstr,
    input  wire logic        globalIrqDisableInstr,
    input  wire logic        sleeping,
    output logic             irqReq,
    output logic             wakeReq,
    output logic             convStart,
    output logic             convRunning
);
    // ========================================
    // state
    typedef struct packed {
        logic [7:0]  flags;
        logic [7:0]  mask;
        logic [2:0]  wakeEn;
        logic        lvFlag;
        logic        lvIe;
        logic        lvWe;
        logic        lvEn;
        logic [1:0]  lvSel;
        logic        convRun;
        logic [11:0] result;
        logic        gie;
        logic [7:0]  p6S1;
        logic [7:0]  p6S2;
        logic [7:0]  p6S3;
        logic [2:0]  cmpS;
        logic [2:0]  extS;
        logic [3:0]  lvS1;
        logic [3:0]  lvS2;
        logic        wrPend;
        logic [7:0]  wrAddr;
        logic [31:0] rdata;
        logic        ready;
        logic        irq;
        logic        wake;
        logic        start;
        logic        resp;
    } iwl_state_t;

    iwl_state_t st_r;
    iwl_state_t st_nxt;

    logic [7:0] evVec;
    logic [7:0] riseVec;
    logic       lowHit;
    logic       lvStateN;
    logic       lvRise;
    logic       addrOk;
    logic       rdFlags;
    logic       rdWake;
    logic [7:0] wd;

    // short local names for the flag positions except the pulse range, declared before any use
    localparam int BIT_CMP   = iwl_pkg::BIT_CMP;
    localparam int BIT_CONV  = iwl_pkg::BIT_CONV;
    localparam int BIT_EXT   = iwl_pkg::BIT_EXT;
    localparam int BIT_PINCH = iwl_pkg::BIT_PINCH;
    localparam int BIT_TMR   = iwl_pkg::BIT_TMR;

    // ========================================
    // event detection; pins on synchronised copies, same-clock sources direct
    always_comb begin
        evVec = 8'h00;
        evVec[BIT_CMP]   = st_r.cmpS[1] ^ st_r.cmpS[2];
        evVec[iwl_pkg::BIT_PW3:iwl_pkg::BIT_PW1] = pulseDone;
        evVec[BIT_CONV]  = convDone & st_r.convRun;
        evVec[BIT_EXT]   = st_r.extS[2] & ~st_r.extS[1];
        evVec[BIT_PINCH] = |(st_r.p6S2 ^ st_r.p6S3);
        evVec[BIT_TMR]   = timerOverflow;
    end

    // level code indexes the comparator bank directly
    assign lowHit   = st_r.lvEn & st_r.lvS2[st_r.lvSel];
    assign lvStateN = ~lowHit;
    assign addrOk   = hsel & htrans[1] & hready;
    assign wd       = hwdata[7:0];

    // ========================================
    // next state: bus write, then hardware sets, then read-back
    always_comb begin
        st_nxt = st_r;
        // two-stage synchronisers, third stage only for edges
        // a pin change costs two or three cycles before its flag shows;
        // the trade buys freedom from metastable flag updates
        st_nxt.p6S1 = port6In;
        st_nxt.p6S2 = st_r.p6S1;
        st_nxt.p6S3 = st_r.p6S2;
        st_nxt.cmpS = {st_r.cmpS[1:0], cmpOut};
        st_nxt.extS = {st_r.extS[1:0], extIrq_n};
        st_nxt.lvS1 = supplyBelow;
        st_nxt.lvS2 = st_r.lvS1;
        st_nxt.start = 1'b0;
        st_nxt.resp  = 1'b0;                // only OKAY is ever returned
        // data phase of a write taken last cycle
        if (st_r.wrPend) begin
            case (st_r.wrAddr)
                iwl_pkg::OFS_FLAGS: st_nxt.flags = st_r.flags & wd;
                iwl_pkg::OFS_MASK:  st_nxt.mask = wd;
                iwl_pkg::OFS_WAKE:  st_nxt.wakeEn = wd[3:1];
                iwl_pkg::OFS_LVC: begin
                    st_nxt.lvFlag = st_r.lvFlag & wd[iwl_pkg::LVC_FLAG];
                    st_nxt.lvIe   = wd[iwl_pkg::LVC_IE];
                    st_nxt.lvWe   = wd[iwl_pkg::LVC_WE];
                    st_nxt.lvEn   = wd[iwl_pkg::LVC_EN];
                    st_nxt.lvSel  = wd[1:0];
                end
                iwl_pkg::OFS_CONV: begin
                    // a zero write cannot stop a conversion
                    if (wd[0] && !st_r.convRun) begin
                        st_nxt.convRun = 1'b1;
                        st_nxt.start   = 1'b1;
                    end
                end
                default: st_nxt.mask = st_nxt.mask;
            endcase
        end
        // completion ends the run in the same edge as the flag
        if (evVec[BIT_CONV]) begin
            st_nxt.convRun = 1'b0;
            st_nxt.result  = convResult;
        end
        // hardware sets last so they win over a clear
        st_nxt.flags = st_nxt.flags | evVec;
        // detector off clears the flag; low level sets it
        if (!st_r.lvEn) begin
            st_nxt.lvFlag = 1'b0;
        end
        if (lowHit) begin
            st_nxt.lvFlag = 1'b1;
        end
        // instruction strobes; disable wins if both arrive
        if (globalIrqEnableInstr) begin
            st_nxt.gie = 1'b1;
        end
        if (globalIrqDisableInstr) begin
            st_nxt.gie = 1'b0;
        end
        // address phase capture
        st_nxt.wrPend = addrOk & hwrite;
        st_nxt.wrAddr = haddr;
        st_nxt.ready  = 1'b1;
        // read from the updated copy so a write is seen at once
        if (addrOk && !hwrite) begin
            case (haddr)
                iwl_pkg::OFS_FLAGS:
                    st_nxt.rdata = {24'h00_0000, st_nxt.flags & st_nxt.mask};
                iwl_pkg::OFS_MASK:
                    st_nxt.rdata = {24'h00_0000, st_nxt.mask};
                iwl_pkg::OFS_WAKE:
                    st_nxt.rdata = {28'h000_0000, st_nxt.wakeEn, 1'b0};
                iwl_pkg::OFS_LVC:
                    st_nxt.rdata = {25'h000_0000, st_nxt.lvFlag, lvStateN,
                                    st_nxt.lvIe, st_nxt.lvWe, st_nxt.lvEn,
                                    st_nxt.lvSel};
                iwl_pkg::OFS_CONV:
                    st_nxt.rdata = {31'h0000_0000, st_nxt.convRun};
                iwl_pkg::OFS_RES:
                    st_nxt.rdata = {20'h0_0000, st_nxt.result};
                iwl_pkg::OFS_GIE:
                    st_nxt.rdata = {31'h0000_0000, st_nxt.gie};
                default:
                    st_nxt.rdata = iwl_pkg::RST_RDATA;  // unmapped reads zero
            endcase
        end
        // interrupt line: masked flags or enabled low voltage, gated globally
        st_nxt.irq = st_nxt.gie & ((|(st_nxt.flags & st_nxt.mask))
                     | (st_nxt.lvFlag & st_nxt.lvIe));
        // wake only from sources that carry an enable bit
        st_nxt.wake = sleeping & ((|(riseVec[7:1] & {1'b1, 3'b000, 1'b1, 1'b0, 1'b1}
                      & {st_r.wakeEn[1], 3'b000, st_r.wakeEn[2], 1'b0,
                         st_r.wakeEn[0]})) | (lvRise & st_r.lvWe));
    end

    // flags newly becoming set this cycle, per source
    assign riseVec = (st_r.flags | evVec) & ~st_r.flags;
    assign lvRise  = lowHit & ~st_r.lvFlag;

    // ========================================
    // state register; synchronous reset to constants only
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st_r        <= '0;
            st_r.flags  <= iwl_pkg::RST_FLAGS;
            st_r.mask   <= iwl_pkg::RST_MASK;
            st_r.wakeEn <= iwl_pkg::RST_WAKE;
            st_r.lvSel  <= iwl_pkg::RST_LVSEL;
            st_r.result <= iwl_pkg::RST_RES;
            st_r.extS   <= 3'b111;          // pin idles high
            st_r.rdata  <= iwl_pkg::RST_RDATA;
            st_r.ready  <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign hrdata      = st_r.rdata;
    assign hreadyout   = st_r.ready;
    assign hresp       = st_r.resp;         // always OKAY, still from a flop
    assign irqReq      = st_r.irq;
    assign wakeReq     = st_r.wake;
    assign convStart   = st_r.start;
    assign convRunning = st_r.convRun;

    // ========================================
    // checks
    assign rdFlags = addrOk & ~hwrite & (haddr == iwl_pkg::OFS_FLAGS);
    assign rdWake  = addrOk & ~hwrite & (haddr == iwl_pkg::OFS_WAKE);

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence seqPinChange;
        st_r.p6S2 != st_r.p6S3;
    endsequence
    sequence seqExtFall;
        st_r.extS[2] && !st_r.extS[1];
    endsequence

    flag_read_a: assert property (rdFlags |=>
        hrdata[7:0] == (st_r.flags & st_r.mask))
        else $error("flag read not masked");
    no_sw_set_a: assert property (##1
        (st_r.flags & ~$past(st_r.flags) & ~$past(evVec)) == 8'h00)
        else $error("flag set without event");
    cmp_set_a: assert property (evVec[BIT_CMP] |=>
        st_r.flags[BIT_CMP])
        else $error("comparator flag missed");
    set_wins_a: assert property ((evVec != 8'h00) |=>
        (st_r.flags & $past(evVec)) == $past(evVec))
        else $error("event lost to clear");
    ext_fall_a: assert property (seqExtFall |=> st_r.flags[BIT_EXT])
        else $error("falling edge missed");
    pin_change_a: assert property (seqPinChange |=>
        st_r.flags[BIT_PINCH])
        else $error("port change missed");
    conv_done_a: assert property (convDone && st_r.convRun |=>
        !st_r.convRun && st_r.flags[BIT_CONV]
        && st_r.result == $past(convResult))
        else $error("completion not atomic");
    conv_hold_a: assert property (st_r.convRun && !convDone |=>
        st_r.convRun)
        else $error("running bit dropped");
    wake_zero_a: assert property (rdWake |=>
        hrdata[7:4] == 4'h0 && hrdata[0] == 1'b0)
        else $error("wake reserved bits set");
    lv_off_a: assert property (!st_r.lvEn |-> lvStateN)
        else $error("state low while off");
    gie_gate_a: assert property (!st_nxt.gie |=> !irqReq)
        else $error("irq while globally off");
    lv_gate_a: assert property (!st_nxt.lvIe
        && (st_nxt.flags & st_nxt.mask) == 8'h00 |=> !irqReq)
        else $error("low-voltage irq while disabled");
    lv_wake_a: assert property (sleeping && lvRise && !st_r.lvWe
        && riseVec == 8'h00 |=> !wakeReq)
        else $error("low-voltage wake while disabled");
    wake_req_a: assert property (sleeping && riseVec[BIT_CMP]
        && st_r.wakeEn[1] |=> wakeReq)
        else $error("wake request missed");

    // ========================================
    // further checks: conversion, flag holding, gating and wake

    // a start write that finds the converter idle
    sequence seqStartWrite;
        st_r.wrPend && st_r.wrAddr == iwl_pkg::OFS_CONV && wd[0] && !st_r.convRun;
    endsequence
    // sleeping with a newly set conversion flag and its wake enable on
    sequence seqConvWake;
        sleeping && riseVec[BIT_CONV] && st_r.wakeEn[2];
    endsequence
    // sleeping with a newly set pin-change flag and its wake enable on
    sequence seqPinWake;
        sleeping && riseVec[BIT_PINCH] && st_r.wakeEn[0];
    endsequence

    // a start write raises running and one start strobe
    run_start_a: assert property (seqStartWrite |=>
        convRunning && convStart)
        else $error("conversion not started");
    start_pulse_a: assert property (convStart |=> !convStart)
        else $error("start strobe too long");

    // result moves only on a counted completion, so stale data stays out
    result_hold_a: assert property (!(convDone && st_r.convRun) |=>
        $stable(st_r.result))
        else $error("result changed without completion");

    // no event and no write: flags keep their value
    flags_hold_a: assert property (!st_r.wrPend && evVec == 8'h00 |=>
        $stable(st_r.flags))
        else $error("flag changed on its own");

    // pulse and timer events reach their flags one edge later
    pulse_set_a: assert property (pulseDone != 3'b000 |=>
        (st_r.flags[iwl_pkg::BIT_PW3:iwl_pkg::BIT_PW1] & $past(pulseDone)) == $past(pulseDone))
        else $error("pulse flag missed");
    tmr_set_a: assert property (timerOverflow |=> st_r.flags[BIT_TMR])
        else $error("timer flag missed");

    // instruction strobes move the global enable; disable wins a tie
    gie_on_a: assert property (globalIrqEnableInstr && !globalIrqDisableInstr
        |=> st_r.gie)
        else $error("global enable not set");
    gie_off_a: assert property (globalIrqDisableInstr |=> !st_r.gie)
        else $error("global enable not cleared");

    // a low level sets the low-voltage flag; a disabled detector clears it
    lv_set_a: assert property (lowHit |=> st_r.lvFlag)
        else $error("low-voltage flag missed");
    lv_clear_a: assert property (!st_r.lvEn |=> !st_r.lvFlag)
        else $error("low-voltage flag kept while off");

    // enabled wake sources raise a request; an awake core never gets one
    conv_wake_a: assert property (seqConvWake |=> wakeReq)
        else $error("conversion wake missed");
    pin_wake_a: assert property (seqPinWake |=> wakeReq)
        else $error("pin-change wake missed");
    awake_quiet_a: assert property (!sleeping |=> !wakeReq)
        else $error("wake request while awake");
endmodule // iwl_top

// [iwl_src_model.sv]
// conversion partner: answers a start with a done pulse and a result
`timescale 1ns/100ps
module iwl_src_model #(
    parameter int          CONV_CYCLES = 8,
    parameter logic [11:0] RESULT      = 12'h0ABC
) (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        convStart,
    output logic             convDone,
    output logic      [11:0] convResult
);
    // ========================================
    // conversion timer
    int cnt;
    // result is valid only with the done pulse; inverted otherwise so stale use shows
    always_ff @(posedge clock) begin
        convDone   <= 1'b0;
        convResult <= ~RESULT;
        if (!rst_n) begin
            cnt <= 0;
        end else if (convStart) begin
            cnt <= CONV_CYCLES;
        end else if (cnt == 1) begin
            cnt        <= 0;
            convDone   <= 1'b1;
            convResult <= RESULT;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule // iwl_src_model

// [testbench.sv]
// self-checking testbench for the interrupt, wake and low-voltage block
`timescale 1ns/100ps
module testbench;
    // ========================================
    // signals
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        hsel = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic        hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        convDone;
    logic [11:0] convResult;
    logic [2:0]  pulseDone = 3'b000;
    logic        timerOverflow = 1'b0;
    logic        cmpOut = 1'b0;
    logic        extIrq_n = 1'b1;
    logic [7:0]  port6In = 8'h00;
    logic [3:0]  supplyBelow = 4'h0;
    logic        gieOn = 1'b0;
    logic        gieOff = 1'b0;
    logic        sleeping = 1'b0;
    logic        irqReq;
    logic        wakeReq;
    logic        convStart;
    logic        convRunning;
    logic        hit;
    logic [31:0] rdata;
    int          nMismatch = 0;
    int          checked = 0;

    always #5 clock = ~clock;
    // single slave, so its ready is the bus ready
    assign hready = hreadyout;

    iwl_top iwl_top_inst (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .pulseDone(pulseDone),
        .convDone(convDone), .convResult(convResult), .timerOverflow(timerOverflow),
        .cmpOut(cmpOut), .extIrq_n(extIrq_n), .port6In(port6In), .supplyBelow(supplyBelow),
        .globalIrqEnableInstr(gieOn), .globalIrqDisableInstr(gieOff), .sleeping(sleeping),
        .irqReq(irqReq), .wakeReq(wakeReq), .convStart(convStart), .convRunning(convRunning));

    iwl_src_model iwl_src_model_inst (.clock(clock), .rst_n(rst_n), .convStart(convStart),
        .convDone(convDone), .convResult(convResult));

    // ========================================
    // bus tasks and compare
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            nMismatch++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one single word: hold each phase until ready is sampled high
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge clock); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clock); while (hready !== 1'b1);
        rdata = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0000_0000);
        chk(rdata, exp);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    // note any wake request seen over n edges
    task automatic watchWake(input int n);
        hit = 1'b0;
        repeat (n) begin
            @(posedge clock);
            if (wakeReq === 1'b1) hit = 1'b1;
        end
    endtask
    task automatic completeRun();
        $display("comparisons %0d mismatches %0d", checked, nMismatch);
        if (nMismatch == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ========================================
    // watchdog: the whole sequence needs well under 2000 cycles
    initial begin
        tick(5000);
        nMismatch++;
        completeRun();
    end

    // ========================================
    // main sequence
    initial begin
        tick(2);
        rst_n <= 1'b1;
        @(posedge clock);
        rdc(iwl_pkg::OFS_LVC, 32'h0000_0020);
        wr(iwl_pkg::OFS_MASK, 32'h0000_00FF);
        rdc(iwl_pkg::OFS_FLAGS, 32'h0000_0000);
        wr(iwl_pkg::OFS_WAKE, 32'hFFFF_FFFF);
        rdc(iwl_pkg::OFS_WAKE, 32'h0000_000E);
        rdc(8'h40, 32'h0000_0000);
        // same-clock sources
        timerOverflow <= 1'b1;
        pulseDone     <= 3'b111;
        @(posedge clock);
        timerOverflow <= 1'b0;
        pulseDone     <= 3'b000;
        rdc(iwl_pkg::OFS_FLAGS, 32'h0000_0071);
        wr(iwl_pkg::OFS_MASK, 32'h0000_000F);
        rdc(iwl_pkg::OFS_FLAGS, 32'h0000_0001);
        wr(iwl_pkg::OFS_MASK, 32'h0000_00FF);
        wr(iwl_pkg::OFS_FLAGS, 32'h0000_00FF);
        rdc(iwl_pkg::OFS_FLAGS, 32'h0000_0071);
        wr(iwl_pkg::OFS_FLAGS, 32'h0000_008E);
        rdc(iwl_pkg::OFS_FLAGS, 32'h0000_0000);
        // event held through the clearing write: the set must win
        timerOverflow <= 1'b1;
        wr(iwl_pkg::OFS_FLAGS, 32'h0000_0000);
        timerOverflow <= 1'b0;
        rdc(iwl_pkg::OFS_FLAGS, 32'h0000_0001);
        wr(iwl_pkg::OFS_FLAGS, 32'h0000_0000);
        // pins pass a synchroniser, so allow a few cycles
        extIrq_n <= 1'b0;
        tick(6);
        rdc(iwl_pkg::OFS_FLAGS, 32'h0000_0004);
        wr(iwl_pkg::OFS_FLAGS, 32'h0000_0000);
        extIrq_n <= 1'b1;
        port6In  <= 8'h10;
        tick(6);
        rdc(iwl_pkg::OFS_FLAGS, 32'h0000_0002);
        wr(iwl_pkg::OFS_FLAGS, 32'h0000_0000);
        // comparator change while asleep must wake the core
        sleeping <= 1'b1;
        cmpOut   <= 1'b1;
        watchWake(10);
        chk({31'b0, hit}, 32'h0000_0001);
        rdc(iwl_pkg::OFS_FLAGS, 32'h0000_0080);
        // port change wakes only with its own enable
        wr(iwl_pkg::OFS_WAKE, 32'h0000_000C);
        port6In <= 8'h30;
        watchWake(10);
        chk({31'b0, hit}, 32'h0000_0000);
        wr(iwl_pkg::OFS_FLAGS, 32'h0000_0080);
        wr(iwl_pkg::OFS_WAKE, 32'h0000_0002);
        port6In <= 8'h10;
        watchWake(10);
        chk({31'b0, hit}, 32'h0000_0001);
        sleeping <= 1'b0;
        // global enable by instruction strobes
        gieOn <= 1'b1;
        @(posedge clock);
        gieOn <= 1'b0;
        tick(2);
        chk({31'b0, irqReq}, 32'h0000_0001);
        rdc(iwl_pkg::OFS_GIE, 32'h0000_0001);
        gieOff <= 1'b1;
        @(posedge clock);
        gieOff <= 1'b0;
        tick(2);
        chk({31'b0, irqReq}, 32'h0000_0000);
        wr(iwl_pkg::OFS_FLAGS, 32'h0000_0000);
        // conversion: software cannot stop it, completion does three things at once
        wr(iwl_pkg::OFS_WAKE, 32'h0000_0008);
        sleeping <= 1'b1;
        wr(iwl_pkg::OFS_CONV, 32'h0000_0001);
        wr(iwl_pkg::OFS_CONV, 32'h0000_0000);
        chk({31'b0, convRunning}, 32'h0000_0001);
        hit = 1'b0;
        for (int i = 0; i < 30 && convRunning === 1'b1; i++) begin
            @(posedge clock);
            if (wakeReq === 1'b1) hit = 1'b1;
        end
        sleeping <= 1'b0;
        chk({31'b0, hit}, 32'h0000_0001);
        rdc(iwl_pkg::OFS_CONV, 32'h0000_0000);
        rdc(iwl_pkg::OFS_RES, 32'h0000_0ABC);
        rdc(iwl_pkg::OFS_FLAGS, 32'h0000_0008);
        // each level code: just above its threshold, then below it
        for (int c = 0; c < 4; c++) begin
            wr(iwl_pkg::OFS_LVC, 32'h0000_0014 | 32'(c));
            supplyBelow <= (4'h1 << c) - 4'h1;
            tick(6);
            rdc(iwl_pkg::OFS_LVC, 32'h0000_0034 | 32'(c));
            supplyBelow <= (4'h2 << c) - 4'h1;
            tick(6);
            rdc(iwl_pkg::OFS_LVC, 32'h0000_0054 | 32'(c));
            supplyBelow <= 4'h0;
            tick(6);
            wr(iwl_pkg::OFS_LVC, 32'h0000_0014 | 32'(c));
            rdc(iwl_pkg::OFS_LVC, 32'h0000_0034 | 32'(c));
        end
        // low-voltage wake, then interrupt gated by its own enable
        wr(iwl_pkg::OFS_FLAGS, 32'h0000_0000);
        wr(iwl_pkg::OFS_LVC, 32'h0000_000C);
        sleeping    <= 1'b1;
        supplyBelow <= 4'h1;
        watchWake(8);
        chk({31'b0, hit}, 32'h0000_0001);
        gieOn <= 1'b1;
        @(posedge clock);
        gieOn <= 1'b0;
        tick(2);
        chk({31'b0, irqReq}, 32'h0000_0000);
        wr(iwl_pkg::OFS_LVC, 32'h0000_001C);
        tick(2);
        chk({31'b0, irqReq}, 32'h0000_0001);
        gieOff <= 1'b1;
        @(posedge clock);
        gieOff   <= 1'b0;
        sleeping <= 1'b0;
        supplyBelow <= 4'hF;
        wr(iwl_pkg::OFS_LVC, 32'h0000_0003);
        tick(6);
        rdc(iwl_pkg::OFS_LVC, 32'h0000_0023);
        completeRun();
    end
endmodule // testbench
